// ---- include/tlw_pkg.sv ----
/*
  Shared constants for the translation entry low word port: selector,
  field positions in the low word, zone codes and configuration codes.
  Assumes bit 0 of each constant is the least significant bit.
*/
package tlw_pkg;
   localparam int SEL_W = 14;
   localparam logic [13:0] SEL_LOW_WORD = 14'h1003;
   localparam int WORD_W = 32;
   localparam logic [31:0] LOW_WORD_RESET = 32'h0000_0000;
   // Attribute positions, counted from the low end of an n-bit entry
   localparam int GUARD_BIT = 0;
   localparam int COHERENT_BIT = 1;
   localparam int INHIBIT_BIT = 2;
   localparam int WTHRU_BIT = 3;
   localparam int ZONE_LSB = 4;
   localparam int ZONE_W = 4;
   localparam int STORE_BIT = 8;
   localparam int FETCH_BIT = 9;
   localparam int RPN_LSB = 10;
   localparam int RPN_MAX_W = 54;
   localparam int ZONE_COUNT = 16;
   localparam int ZONE_FIELD_W = 2;
   localparam logic [1:0] ZONE_DENY = 2'h0;
   localparam logic [1:0] ZONE_GRANT = 2'h3;
   localparam int SIZE_W = 3;
   localparam int PAGE_SHIFT_BASE = 10;
   localparam int PAGE_SHIFT_STEP = 2;
   localparam int MMU_USER_MIN = 2;
   localparam int MMU_VIRTUAL = 3;
   localparam int GOAL_PERF = 0;
   localparam int GOAL_FREQ = 2;
   localparam int TLB_READ_MIN = 1;
endpackage

// ---- rtl/tlw_entry_store.sv ----
/*
  Storage of the low words of all buffer entries: one write port,
  two asynchronous read ports (software access and translation).
  Assumes the configuration load clears the array; no reset input.
*/
`timescale 1ns/1ps
module tlw_entry_store import tlw_pkg::*;
#(
   parameter int W = 32,
   parameter int IDX_W = 6
)
(
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [IDX_W-1:0] widx_i,
   input wire logic [W-1:0] wdata_i,
   input wire logic [IDX_W-1:0] ridx_a_i,
   output logic [W-1:0] rdata_a_o,
   input wire logic [IDX_W-1:0] ridx_b_i,
   output logic [W-1:0] rdata_b_o
);
   // Cleared only by the configuration load, never by a reset
   logic [W-1:0] mem_q [2**IDX_W] = '{default: W'(LOW_WORD_RESET)};

   always_ff @(posedge clk_i)
   begin
      if (we_i)
      begin
         mem_q[widx_i] <= wdata_i;
      end
   end

   assign rdata_a_o = mem_q[ridx_a_i];
   assign rdata_b_o = mem_q[ridx_b_i];
endmodule // tlw_entry_store

// ---- rtl/tlw_low_word.sv ----
/*
  Special-register port to the low word of the unified translation
  buffer entries, plus the attribute decode used on a translation hit.
  Assumes the core supplies the entry index, the hit index, the page
  size and valid bit of the high word, and the zone override value.
*/
`timescale 1ns/1ps
module tlw_low_word import tlw_pkg::*;
#(
   parameter int MMU_LEVEL = 3,
   parameter int IMPL_GOAL = 0,
   parameter int TLB_ACCESS = 3,
   parameter int WRITEBACK = 1,
   parameter int DATA_SIZE = 32,
   parameter int ADDR_SIZE = 32,
   parameter int IDX_W = 6
)
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic spr_read_i,
   input wire logic spr_write_i,
   input wire logic spr_ext_i,
   input wire logic [SEL_W-1:0] spr_sel_i,
   input wire logic [DATA_SIZE-1:0] spr_wdata_i,
   input wire logic [IDX_W-1:0] entry_index_i,
   output logic [DATA_SIZE-1:0] spr_rdata_o,
   output logic spr_rvalid_o,
   input wire logic lookup_i,
   input wire logic fetch_i,
   input wire logic store_i,
   input wire logic user_mode_i,
   input wire logic entry_valid_i,
   input wire logic [IDX_W-1:0] hit_index_i,
   input wire logic [SIZE_W-1:0] page_size_i,
   input wire logic [ADDR_SIZE-1:0] vaddr_i,
   input wire logic [ZONE_COUNT*ZONE_FIELD_W-1:0] zone_override_i,
   output logic lookup_done_o,
   output logic [ADDR_SIZE-1:0] paddr_o,
   output logic fetch_fault_o,
   output logic store_fault_o,
   output logic no_access_o,
   output logic cacheable_o,
   output logic write_through_o,
   output logic guarded_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Configuration
   localparam bit PHYSICAL_ADDRESS_EXTENSION = (DATA_SIZE == WORD_W) && (MMU_LEVEL == MMU_VIRTUAL) && (ADDR_SIZE > WORD_W);
   localparam bit WIDE = PHYSICAL_ADDRESS_EXTENSION || (DATA_SIZE == 2 * WORD_W);
   localparam int EW = WIDE ? ADDR_SIZE : WORD_W;
   localparam int UPW = (EW > WORD_W) ? EW - WORD_W : 1;
   localparam bit IMPL = (MMU_LEVEL >= MMU_USER_MIN) && ((IMPL_GOAL == GOAL_PERF) || (IMPL_GOAL == GOAL_FREQ));
   localparam bit READABLE = (TLB_ACCESS >= TLB_READ_MIN);

   typedef struct packed {
      logic [UPW-1:0] hold;
      logic [DATA_SIZE-1:0] rdata;
      logic rvalid;
      logic rd_upper;
      logic done;
      logic [ADDR_SIZE-1:0] paddr;
      logic ffault;
      logic sfault;
      logic noacc;
      logic cach;
      logic wthru;
      logic guard;
   } tlw_state_type;

   tlw_state_type state_q;
   tlw_state_type state_d;
   logic rst_n;
   logic hit_sel;
   logic wr_lo;
   logic wr_hi;
   logic [EW-1:0] wr_word;
   logic [EW-1:0] acc_raw;
   logic [EW-1:0] lk_raw;
   logic [EW-1:0] acc_entry;
   logic [EW-1:0] lk_entry;
   logic [ZONE_W-1:0] zone_sel;
   logic [ZONE_FIELD_W-1:0] zone_field;
   logic zone_deny;
   logic zone_grant;
   logic access_ok;
   logic ex_ok;
   logic wr_ok;

   // Fixed bits are forced on read only, not on write, so a word cleared
   // by the configuration load still reads back with its fixed values
   function automatic logic [EW-1:0] fix_word(input logic [EW-1:0] w);
      logic [EW-1:0] f;
      f = w;
      f[COHERENT_BIT] = 1'b0;
      if (WRITEBACK == 0)
      begin
         f[WTHRU_BIT] = 1'b1;
      end
      if (MMU_LEVEL != MMU_VIRTUAL)
      begin
         f[EW-1:RPN_LSB] = '0;
      end
      return f;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Reset and storage
   tlw_reset_sync u_reset_sync
   (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .rst_n_o(rst_n)
   );

   // The store has no reset port at all, so neither reset can clear it
   tlw_entry_store #(.W(EW), .IDX_W(IDX_W)) u_store
   (
      .clk_i(clk_i),
      .we_i(wr_lo),
      .widx_i(entry_index_i),
      .wdata_i(wr_word),
      .ridx_a_i(entry_index_i),
      .rdata_a_o(acc_raw),
      .ridx_b_i(hit_index_i),
      .rdata_b_o(lk_raw)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Special-register decode
   assign hit_sel = IMPL && (spr_sel_i == SEL_LOW_WORD);
   // Extended moves are ignored unless the extension is active
   assign wr_lo = spr_write_i && hit_sel && !spr_ext_i;
   assign wr_hi = spr_write_i && hit_sel && spr_ext_i && PHYSICAL_ADDRESS_EXTENSION;
   // The lower write commits the upper part latched before it; a
   // lower write without a prior upper write reuses the old latch
   assign wr_word = PHYSICAL_ADDRESS_EXTENSION ? EW'({state_q.hold, spr_wdata_i[WORD_W-1:0]}) : EW'(spr_wdata_i);
   assign acc_entry = fix_word(acc_raw);
   assign lk_entry = fix_word(lk_raw);

   ////////////////////////////////////////////////////////////////////////////
   // Translation attribute decode
   assign zone_sel = lk_entry[ZONE_LSB +: ZONE_W];
   assign zone_field = zone_override_i[(ZONE_COUNT - 1 - int'(zone_sel)) * ZONE_FIELD_W +: ZONE_FIELD_W];
   assign zone_deny = user_mode_i && (zone_field == ZONE_DENY);
   assign zone_grant = user_mode_i ? (zone_field == ZONE_GRANT) : zone_field[1];
   assign access_ok = entry_valid_i && !zone_deny;
   assign ex_ok = access_ok && (zone_grant || lk_entry[FETCH_BIT]);
   assign wr_ok = access_ok && (zone_grant || lk_entry[STORE_BIT]);

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      logic [ADDR_SIZE-1:0] off_mask;
      int shift_amt;
      state_d = state_q;
      shift_amt = PAGE_SHIFT_BASE + PAGE_SHIFT_STEP * int'(page_size_i);
      off_mask = ~({ADDR_SIZE{1'b1}} << shift_amt);
      if (wr_hi)
      begin
         state_d.hold = spr_wdata_i[UPW-1:0];
      end
      state_d.rvalid = spr_read_i && hit_sel && (!spr_ext_i || PHYSICAL_ADDRESS_EXTENSION);
      state_d.rd_upper = spr_ext_i;
      if (spr_read_i && hit_sel)
      begin
         if (!READABLE)
         begin
            state_d.rdata = '0;
         end
         else if (spr_ext_i)
         begin
            state_d.rdata = PHYSICAL_ADDRESS_EXTENSION ? DATA_SIZE'(acc_entry >> WORD_W) : '0;
         end
         else
         begin
            // A wide datapath returns the whole entry, a narrow one the low WORD_W bits
            state_d.rdata = DATA_SIZE'(acc_entry);
         end
      end
      state_d.done = lookup_i;
      state_d.ffault = lookup_i && fetch_i && !ex_ok;
      state_d.sfault = lookup_i && store_i && !wr_ok;
      if (lookup_i)
      begin
         // Offset bits come from the virtual address, the rest from the page number
         state_d.paddr = (ADDR_SIZE'(lk_entry) & ~off_mask) | (vaddr_i & off_mask);
         state_d.noacc = !access_ok;
         state_d.cach = !lk_entry[INHIBIT_BIT];
         state_d.wthru = lk_entry[WTHRU_BIT];
         state_d.guard = lk_entry[GUARD_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign spr_rdata_o = state_q.rdata;
   assign spr_rvalid_o = state_q.rvalid;
   assign lookup_done_o = state_q.done;
   assign paddr_o = state_q.paddr;
   assign fetch_fault_o = state_q.ffault;
   assign store_fault_o = state_q.sfault;
   assign no_access_o = state_q.noacc;
   assign cacheable_o = state_q.cach;
   assign write_through_o = state_q.wthru;
   assign guarded_o = state_q.guard;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_read_answer;
      @(posedge clk_i) disable iff (!rst_n)
      (spr_read_i && !spr_ext_i && (spr_sel_i == SEL_LOW_WORD) && IMPL) |=> spr_rvalid_o;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("low word read not answered");

   property p_other_sel;
      @(posedge clk_i) disable iff (!rst_n)
      (spr_sel_i != SEL_LOW_WORD) |=> !spr_rvalid_o;
   endproperty
   a_other_sel: assert property (p_other_sel) else $error("answer to foreign selector");

   property p_readback;
      @(posedge clk_i) disable iff (!rst_n)
      (wr_lo && READABLE) ##1 (spr_read_i && hit_sel && !spr_ext_i && (entry_index_i == $past(entry_index_i)))
      |=> spr_rdata_o[FETCH_BIT] == $past(spr_wdata_i[FETCH_BIT], 2);
   endproperty
   a_readback: assert property (p_readback) else $error("readback differs from write");

   property p_coherent_zero;
      @(posedge clk_i) disable iff (!rst_n)
      (spr_rvalid_o && !state_q.rd_upper) |-> !spr_rdata_o[COHERENT_BIT];
   endproperty
   a_coherent_zero: assert property (p_coherent_zero) else $error("coherence bit not zero");

   property p_wthru_fixed;
      @(posedge clk_i) disable iff (!rst_n)
      (spr_rvalid_o && !state_q.rd_upper && READABLE && (WRITEBACK == 0)) |-> spr_rdata_o[WTHRU_BIT];
   endproperty
   a_wthru_fixed: assert property (p_wthru_fixed) else $error("policy bit not fixed to one");

   property p_fetch_fault;
      @(posedge clk_i) disable iff (!rst_n)
      (lookup_i && fetch_i && entry_valid_i && !user_mode_i && !zone_field[1] && !lk_entry[FETCH_BIT])
      |=> fetch_fault_o ##1 !fetch_fault_o || lookup_done_o;
   endproperty
   a_fetch_fault: assert property (p_fetch_fault) else $error("missing fetch fault");

   property p_store_fault;
      @(posedge clk_i) disable iff (!rst_n)
      // Only zones that neither grant nor deny leave the decision to the entry's store bit
      (lookup_i && store_i && entry_valid_i && (user_mode_i ? ^zone_field : !zone_field[1]))
      |=> store_fault_o == !$past(lk_entry[STORE_BIT]);
   endproperty
   a_store_fault: assert property (p_store_fault) else $error("store fault wrong");

   property p_zone_deny;
      @(posedge clk_i) disable iff (!rst_n)
      (lookup_i && user_mode_i && (zone_field == ZONE_DENY)) |=> no_access_o && lookup_done_o;
   endproperty
   a_zone_deny: assert property (p_zone_deny) else $error("denied zone left accessible");

   property p_inhibit;
      @(posedge clk_i) disable iff (!rst_n)
      lookup_done_o |-> (cacheable_o != $past(lk_entry[INHIBIT_BIT])) && (guarded_o == $past(lk_entry[GUARD_BIT]));
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("cache or guard attribute wrong");

   property p_offset;
      @(posedge clk_i) disable iff (!rst_n)
      lookup_i |=> paddr_o[PAGE_SHIFT_BASE-1:0] == $past(vaddr_i[PAGE_SHIFT_BASE-1:0]);
   endproperty
   a_offset: assert property (p_offset) else $error("page offset not passed through");
endmodule // tlw_low_word

// ---- rtl/tlw_reset_sync.sv ----
/*
  Two-stage release synchroniser for the active-low reset.
  Assumes resetn_i may drop at any time; release is aligned to clk_i.
*/
`timescale 1ns/1ps
module tlw_reset_sync
(
   input wire logic clk_i,
   input wire logic resetn_i,
   output logic rst_n_o
);
   logic [1:0] sync_q;

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sync_q <= 2'h0;
      end
      else
      begin
         sync_q <= {sync_q[0], 1'b1};
      end
   end

   assign rst_n_o = sync_q[1];
endmodule // tlw_reset_sync

// ---- test/tlw_core_model.sv ----
/*
  Core-side model: issues special-register moves to the low word port.
  Assumes a free-running clk_i; every move is launched just after a rising edge.
*/
`timescale 1ns/1ps
module tlw_core_model import tlw_pkg::*;
(
   input wire logic clk_i,
   output logic spr_read_o,
   output logic spr_write_o,
   output logic spr_ext_o,
   output logic [SEL_W-1:0] spr_sel_o,
   output logic [WORD_W-1:0] spr_wdata_o,
   output logic [5:0] entry_index_o
);
   initial
   begin
      spr_read_o = 1'b0;
      spr_write_o = 1'b0;
      spr_ext_o = 1'b0;
      spr_sel_o = 14'h0000;
      spr_wdata_o = 32'h0000_0000;
      entry_index_o = 6'h00;
   end
   ////////////////////////////////////////////////////////////////////////////
   // One move; qualifiers held until the taking edge, then scrambled
   // With a 32-bit word no extended part exists, so one move is the whole write
   task automatic move(input logic wr, input logic ext, input logic [13:0] sel, input logic [5:0] idx,
                       input logic [31:0] data);
   begin
      @(posedge clk_i);
      spr_read_o <= !wr;
      spr_write_o <= wr;
      spr_ext_o <= ext;
      spr_sel_o <= sel;
      spr_wdata_o <= data;
      entry_index_o <= idx;
      @(posedge clk_i);
      spr_read_o <= 1'b0;
      spr_write_o <= 1'b0;
      spr_ext_o <= 1'b0;
      spr_sel_o <= ~sel;
      spr_wdata_o <= ~data;
      entry_index_o <= ~idx;
   end
   endtask
   // Write then read one entry on the very next edge, with no idle cycle between
   task automatic wr_rd(input logic [5:0] idx, input logic [31:0] data);
   begin
      @(posedge clk_i);
      spr_write_o <= 1'b1;
      spr_sel_o <= SEL_LOW_WORD;
      spr_wdata_o <= data;
      entry_index_o <= idx;
      @(posedge clk_i);
      spr_write_o <= 1'b0;
      spr_read_o <= 1'b1;
      @(posedge clk_i);
      spr_read_o <= 1'b0;
      spr_sel_o <= ~SEL_LOW_WORD;
      spr_wdata_o <= ~data;
      entry_index_o <= ~idx;
   end
   endtask
   // Entries survive reset, so software clears all of them; zero leaves unused page bits zero
   task automatic init_all();
   begin
      for (int i = 0; i < 64; i++)
         move(1'b1, 1'b0, SEL_LOW_WORD, 6'(i), 32'h0000_0000);
   end
   endtask
endmodule // tlw_core_model

// ---- test/tlw_low_word_tb_top.sv ----
/*
  Self-checking bench for the low word port and its lookup decode.
  Assumes default design parameters: 32-bit word, no extension, writeback on.
*/
`timescale 1ns/1ps
module tlw_low_word_tb_top import tlw_pkg::*;
;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic lookup_i = 1'b0, fetch_i = 1'b0, store_i = 1'b0, user_mode_i = 1'b0, entry_valid_i = 1'b1;
   logic [5:0] hit_index_i = 6'h00;
   logic [2:0] page_size_i = 3'h0;
   logic [31:0] vaddr_i = 32'h0000_0000, zone_override_i = 32'h0000_0000;
   logic spr_read_i, spr_write_i, spr_ext_i, spr_rvalid_o, lookup_done_o;
   logic [13:0] spr_sel_i;
   logic [5:0] entry_index_i;
   logic [31:0] spr_wdata_i, spr_rdata_o, paddr_o;
   logic fetch_fault_o, store_fault_o, no_access_o, cacheable_o, write_through_o, guarded_o;
   int fail_count = 0, checks_done = 0, cycles = 0;
   initial
   begin
      forever #50 clk_i = ~clk_i;
   end
   tlw_core_model core (.clk_i(clk_i), .spr_read_o(spr_read_i), .spr_write_o(spr_write_i),
      .spr_ext_o(spr_ext_i), .spr_sel_o(spr_sel_i), .spr_wdata_o(spr_wdata_i), .entry_index_o(entry_index_i));
   tlw_low_word dut (.clk_i(clk_i), .resetn_i(resetn_i), .spr_read_i(spr_read_i), .spr_write_i(spr_write_i),
      .spr_ext_i(spr_ext_i), .spr_sel_i(spr_sel_i), .spr_wdata_i(spr_wdata_i), .entry_index_i(entry_index_i),
      .spr_rdata_o(spr_rdata_o), .spr_rvalid_o(spr_rvalid_o), .lookup_i(lookup_i), .fetch_i(fetch_i),
      .store_i(store_i), .user_mode_i(user_mode_i), .entry_valid_i(entry_valid_i), .hit_index_i(hit_index_i),
      .page_size_i(page_size_i), .vaddr_i(vaddr_i), .zone_override_i(zone_override_i),
      .lookup_done_o(lookup_done_o), .paddr_o(paddr_o), .fetch_fault_o(fetch_fault_o),
      .store_fault_o(store_fault_o), .no_access_o(no_access_o), .cacheable_o(cacheable_o),
      .write_through_o(write_through_o), .guarded_o(guarded_o));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
   begin
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   end
   endtask
   task automatic finish_test();
   begin
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask
   // Hang guard: the whole run needs well under a thousand cycles
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         fail_count++;
         finish_test();
      end
   end
   task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
   begin
      core.move(1'b0, 1'b0, SEL_LOW_WORD, idx, 32'h0000_0000);
      #1;
      check("rvalid", {31'h0, spr_rvalid_o}, 32'h0000_0001);
      check("rdata", spr_rdata_o, exp);
   end
   endtask
   task automatic lk(input logic [5:0] idx, input logic f, input logic s, input logic um,
                     input logic [31:0] zov, input logic [31:0] va, input logic [2:0] exp_flt);
   begin
      @(posedge clk_i);
      lookup_i <= 1'b1;
      hit_index_i <= idx;
      fetch_i <= f;
      store_i <= s;
      user_mode_i <= um;
      zone_override_i <= zov;
      vaddr_i <= va;
      @(posedge clk_i);
      lookup_i <= 1'b0;
      #1;
      check("done", {31'h0, lookup_done_o}, 32'h0000_0001);
      check("faults", {29'h0, fetch_fault_o, store_fault_o, no_access_o}, {29'h0, exp_flt});
   end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_power_up();
   begin
      rd_chk(6'h00, LOW_WORD_RESET);
      rd_chk(6'h3f, LOW_WORD_RESET);
      core.init_all();
      $display("test power_up done");
   end
   endtask
   // Coherent bit written as one must read back zero
   task automatic t_access();
   begin
      core.move(1'b1, 1'b0, SEL_LOW_WORD, 6'h03, 32'ha5a5_a3c7);
      core.move(1'b1, 1'b0, SEL_LOW_WORD, 6'h04, 32'h1234_5b7a);
      rd_chk(6'h03, 32'ha5a5_a3c5);
      rd_chk(6'h04, 32'h1234_5b78);
      core.wr_rd(6'h05, 32'h0000_0203);
      #1;
      check("rvalid_b2b", {31'h0, spr_rvalid_o}, 32'h0000_0001);
      check("rdata_b2b", spr_rdata_o, 32'h0000_0201);
      $display("test access done");
   end
   endtask
   task automatic t_refuse();
   begin
      core.move(1'b1, 1'b0, 14'h1004, 6'h03, 32'h0000_0000);
      core.move(1'b0, 1'b0, 14'h1004, 6'h03, 32'h0000_0000);
      #1;
      check("rvalid_sel", {31'h0, spr_rvalid_o}, 32'h0000_0000);
      core.move(1'b1, 1'b1, SEL_LOW_WORD, 6'h03, 32'h0000_0000);
      core.move(1'b0, 1'b1, SEL_LOW_WORD, 6'h03, 32'h0000_0000);
      #1;
      check("rvalid_ext", {31'h0, spr_rvalid_o}, 32'h0000_0000);
      rd_chk(6'h03, 32'ha5a5_a3c5);
      $display("test refuse done");
   end
   endtask
   task automatic t_reset_keep();
   begin
      @(posedge clk_i);
      resetn_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd_chk(6'h04, 32'h1234_5b78);
      $display("test reset_keep done");
   end
   endtask
   // Entry 7: zone 5, store only, inhibit and guard; entry 8: zone 5, fetch only, write-through
   task automatic t_lookup();
   begin
      core.move(1'b1, 1'b0, SEL_LOW_WORD, 6'h07, 32'hc000_0155);
      core.move(1'b1, 1'b0, SEL_LOW_WORD, 6'h08, 32'h0001_0258);
      lk(6'h07, 1'b1, 1'b0, 1'b0, 32'h5555_5555, 32'h0000_03ff, 3'h4);
      check("paddr", paddr_o, 32'hc000_03ff);
      check("attr", {29'h0, cacheable_o, write_through_o, guarded_o}, 32'h0000_0001);
      lk(6'h07, 1'b0, 1'b1, 1'b1, 32'h5555_5555, 32'h0000_0000, 3'h0);
      lk(6'h08, 1'b0, 1'b1, 1'b1, 32'h5555_5555, 32'h0000_0123, 3'h2);
      check("paddr", paddr_o, 32'h0001_0123);
      check("attr", {29'h0, cacheable_o, write_through_o, guarded_o}, 32'h0000_0006);
      lk(6'h08, 1'b1, 1'b0, 1'b1, 32'h5545_5555, 32'h0000_0000, 3'h5);
      lk(6'h08, 1'b0, 1'b1, 1'b0, 32'h5565_5555, 32'h0000_0000, 3'h0);
      // An invalid entry stays inaccessible even where the zone grants access
      @(posedge clk_i);
      entry_valid_i <= 1'b0;
      lk(6'h08, 1'b0, 1'b1, 1'b0, 32'h5565_5555, 32'h0000_0000, 3'h3);
      @(posedge clk_i);
      entry_valid_i <= 1'b1;
      page_size_i <= 3'h1;
      lk(6'h08, 1'b0, 1'b0, 1'b0, 32'h5555_5555, 32'h0000_0abc, 3'h0);
      check("paddr_size1", paddr_o, 32'h0001_0abc);
      $display("test lookup done");
   end
   endtask
   initial
   begin
      repeat (6) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      t_power_up();
      t_access();
      t_refuse();
      t_reset_keep();
      t_lookup();
      finish_test();
   end
endmodule // tlw_low_word_tb_top
